// File: bench/gbe_bus_sink.sv
// Bus side responder taking chunks promptly or with stalls
`timescale 1ns/1ps

module gbe_bus_sink (
   input  wire logic ref_clk_i,   // Clock
   input  wire logic srst_i,      // Reset
   input  wire logic slow_i,      // Stall mode
   output logic      bus_ready_o  // Chunk taken
);
   logic [1:0] cnt_q;

   // Ready every cycle, or one cycle in three when stalling
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         cnt_q       <= 2'h0;
         bus_ready_o <= 1'b0;
      end else begin
         cnt_q       <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
         bus_ready_o <= !slow_i || cnt_q == 2'h1;
      end
   end
endmodule : gbe_bus_sink

// File: bench/gbe_host_request_shaping_tb.sv
// Self-checking bench for the host request shaper
`timescale 1ns/1ps

module gbe_host_request_shaping_tb;
   import gbe_shaping_pkg::*;
   logic ref_clk_i, srst_i, sw_rst_i, req_valid_i, bus_ready_i, slow;
   logic nvm_valid_i, nvm_lan_en_i, half_req_i, sys_s0_i, power_d3_i;
   logic frame_valid_i, rx_valid_i, bcast_en_i, promisc_i, wake_en_i;
   logic hash_spread_en_i, wake_clr_i, req_ready_o, bus_valid_o;
   logic lan_en_o, lane_half_rate_o, link_full_o, link_err_o, pdown_o;
   logic mgmt_active_o, mgmt_clk_o, frame_valid_o, frame_ok_o;
   logic rx_valid_o, rx_accept_o, rx_queue_o, wake_o;
   logic [1:0]   nvm_lan_port_i, speed_req_i, mgmt_rate_i;
   logic [1:0]   lan_port_o, link_speed_o;
   logic [14:0]  rx_buf_req_i, rx_buf_size_o;
   logic [5:0]   rx_fifo_req_i, rx_fifo_kb_o, tx_fifo_kb_o;
   logic [13:0]  frame_len_i;
   logic [47:0]  station_mac_i;
   logic [127:0] mc_table_i;
   dma_req_t     req_i;
   rx_hdr_t      rx_hdr_i;
   bus_req_t     bus_req_o;
   int           n_mismatch = 0;
   int           checks_done = 0;

   gbe_host_request_shaping i_dut (.*);
   gbe_bus_sink i_sink (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
                        .slow_i(slow), .bus_ready_o(bus_ready_i));

   // 50 MHz clock
   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : tick

   task automatic cmp(input string w, input logic [63:0] e, g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %0h seen %0h", w, e, g);
      end
   endtask : cmp

   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out

   // One DMA request, each accepted chunk checked against the split
   task automatic xfer(input logic [63:0] a, input logic [15:0] n,
                       input logic wr, input logic slw);
      logic [15:0] rem, ln, cap;
      int          t;
      rem = n;
      slow <= slw;
      req_i <= '{addr: a, len: n, write: wr};
      req_valid_i <= 1'b1;
      for (t = 0; t < 60; t++) begin
         @(posedge ref_clk_i);
         if (req_ready_o === 1'b1) break;
      end
      req_valid_i <= 1'b0;
      while (rem != 16'h0000 && t < 600) begin
         @(posedge ref_clk_i);
         t++;
         if (bus_valid_o === 1'b1 && bus_ready_i === 1'b1) begin
            ln = 16'h1000 - 16'(a[11:0]);
            cap = wr ? 16'h0080 : 16'h0080 - 16'(a[6:0]);
            if (rem < ln) ln = rem;
            if (cap < ln) ln = cap;
            cmp("chunk addr", a, bus_req_o.addr);
            cmp("chunk len", 64'(ln), 64'(bus_req_o.len));
            cmp("chunk write", 64'(wr), 64'(bus_req_o.write));
            cmp("chunk last", 64'(rem == ln), 64'(bus_req_o.last));
            a += 64'(ln);
            rem -= ln;
         end
      end
      if (rem != 16'h0000) begin
         n_mismatch++;
         close_out();
      end
   endtask : xfer

   task automatic cfg(input logic [14:0] b, eb, input logic [5:0] f, ef);
      rx_buf_req_i <= b;
      rx_fifo_req_i <= f;
      tick(2);
      cmp("rx buffer", 64'(eb), 64'(rx_buf_size_o));
      cmp("rx fifo", 64'(ef), 64'(rx_fifo_kb_o));
      cmp("tx fifo", 64'(6'h20 - ef), 64'(tx_fifo_kb_o));
   endtask : cfg

   task automatic rx(input logic [47:0] d, input logic [31:0] h,
                     input logic wk, ea, eq);
      rx_hdr_i <= '{dst_mac: d, hash: h, wake_pkt: wk, wake_mac: d};
      rx_valid_i <= 1'b1;
      tick(1);
      rx_valid_i <= 1'b0;
      tick(1);
      cmp("rx strobe", 64'h1, 64'(rx_valid_o));
      cmp("rx accept", 64'(ea), 64'(rx_accept_o));
      cmp("rx queue", 64'(eq), 64'(rx_queue_o));
   endtask : rx

   // Main sequence
   initial begin
      logic [1:0] spd;
      logic [7:0] dv [3];
      logic       lv;
      int         n;
      dv = '{MGMT_DIV_100K, MGMT_DIV_400K, MGMT_DIV_1M};
      {srst_i, sys_s0_i, bcast_en_i, hash_spread_en_i} = 4'hF;
      {sw_rst_i, req_valid_i, slow, nvm_valid_i, nvm_lan_en_i} = '0;
      {half_req_i, power_d3_i, frame_valid_i, rx_valid_i} = '0;
      {promisc_i, wake_en_i, wake_clr_i, req_i, rx_hdr_i} = '0;
      {nvm_lan_port_i, speed_req_i, mgmt_rate_i} = '0;
      {rx_buf_req_i, rx_fifo_req_i, frame_len_i} = '0;
      station_mac_i = 48'h0A1B_2C3D_4E5F;
      mc_table_i = 128'h1 << 17;
      tick(8);
      srst_i <= 1'b0;
      xfer(64'h0000_0001_0000_0FC4, 16'h0150, 1'b0, 1'b0);
      xfer(64'h0000_00FF_FFFF_FFA1, 16'h012C, 1'b1, 1'b1);
      xfer(64'h0000_0002_0000_0F80, 16'h0080, 1'b1, 1'b0);
      xfer(64'h0000_0003_0000_1000, 16'h1001, 1'b0, 1'b1);
      power_d3_i <= 1'b1;
      tick(3);
      cmp("ready in d3", 64'h0, 64'(req_ready_o));
      cmp("power down", 64'h1, 64'(pdown_o));
      power_d3_i <= 1'b0;
      // Every rate, duplex and system state
      for (int i = 0; i < 12; i++) begin
         speed_req_i <= 2'(i % 3);
         half_req_i <= 1'((i / 3) % 2);
         sys_s0_i <= 1'(i / 6);
         spd = (i % 3 == 2 && i < 6) ? SPD_100 : 2'(i % 3);
         lv = spd == SPD_1000 || (i / 3) % 2 == 0;
         tick(2);
         cmp("speed", 64'(spd), 64'(link_speed_o));
         cmp("full", 64'(lv), 64'(link_full_o));
         cmp("grant altered", 64'(i % 3 == 2 && (i < 6 || (i / 3) % 2 == 1)),
             64'(link_err_o));
         cmp("mgmt on", 64'(i < 6), 64'(mgmt_active_o));
      end
      sys_s0_i <= 1'b0;
      for (int r = 0; r < 3; r++) begin
         mgmt_rate_i <= 2'(r);
         for (int k = 0; k < 3; k++) begin
            n = 0;
            lv = mgmt_clk_o;
            while (mgmt_clk_o === lv && n < 600) begin
               tick(1);
               n++;
            end
         end
         cmp("mgmt half period", 64'(dv[r]), 64'(n));
      end
      sys_s0_i <= 1'b1;
      cfg(15'h0010, 15'h0100, 6'h3F, 6'h20);
      cfg(15'h7FFF, 15'h4000, 6'h0C, 6'h0C);
      for (int i = 0; i < 2; i++) begin
         frame_len_i <= 14'h233A + 14'(i);
         frame_valid_i <= 1'b1;
         tick(1);
         frame_valid_i <= 1'b0;
         tick(1);
         cmp("frame strobe", 64'h1, 64'(frame_valid_o));
         cmp("frame ok", 64'(i == 0), 64'(frame_ok_o));
      end
      // Filters, queues and wake
      rx(station_mac_i, 32'h1, 1'b0, 1'b1, 1'b1);
      rx(48'h0A1B_2C3D_4E50, 32'h0, 1'b0, 1'b0, 1'b0);
      rx(48'h2300_0000_0001, 32'h3, 1'b0, 1'b1, 1'b1);
      rx(48'h2500_0000_0001, 32'h2, 1'b0, 1'b0, 1'b0);
      rx(MAC_BCAST, 32'h0, 1'b0, 1'b1, 1'b0);
      bcast_en_i <= 1'b0;
      rx(MAC_BCAST, 32'h0, 1'b0, 1'b0, 1'b0);
      {promisc_i, hash_spread_en_i, wake_en_i} <= 3'h5;
      rx(48'h0A1B_2C3D_4E50, 32'h1, 1'b1, 1'b1, 1'b0);
      cmp("wake", 64'h0, 64'(wake_o));
      rx(station_mac_i, 32'h0, 1'b1, 1'b1, 1'b0);
      cmp("wake", 64'h1, 64'(wake_o));
      wake_clr_i <= 1'b1;
      tick(1);
      wake_clr_i <= 1'b0;
      tick(1);
      cmp("wake cleared", 64'h0, 64'(wake_o));
      {nvm_lan_en_i, nvm_lan_port_i, nvm_valid_i} <= 4'hD;
      tick(1);
      nvm_valid_i <= 1'b0;
      rx(station_mac_i, 32'h0, 1'b1, 1'b1, 1'b0);
      cmp("port on", 64'h1, 64'(lan_en_o));
      cmp("half rate", 64'h1, 64'(lane_half_rate_o));
      sw_rst_i <= 1'b1;
      tick(1);
      sw_rst_i <= 1'b0;
      tick(1);
      cmp("wake after soft reset", 64'h0, 64'(wake_o));
      cmp("buffer after soft reset", 64'h0, 64'(rx_buf_size_o));
      cmp("port kept", 64'h2, 64'(lan_port_o));
      close_out();
   end
endmodule : gbe_host_request_shaping_tb

// File: bench/gbe_shaping_monitor.sv
// Port checks for the host request shaper
`timescale 1ns/1ps

module gbe_shaping_monitor
   import gbe_shaping_pkg::*;
(
   input wire logic        ref_clk_i,     // Clock
   input wire logic        srst_i,        // Reset
   input wire logic        sw_rst_i,      // Soft reset
   input wire logic        req_ready_o,   // Request taken
   input wire logic        bus_valid_o,   // Chunk offered
   input wire bus_req_t    bus_req_o,     // Chunk fields
   input wire logic        bus_ready_i,   // Chunk taken
   input wire logic        lan_en_o,      // Port attached
   input wire logic        sys_s0_i,      // Working state
   input wire logic        power_d3_i,    // Powered down
   input wire logic [1:0]  link_speed_o,  // Granted rate
   input wire logic        link_full_o,   // Full duplex
   input wire logic        rx_valid_i,    // Header strobe
   input wire rx_hdr_t     rx_hdr_i,      // Header fields
   input wire logic [47:0] station_mac_i, // Own address
   input wire logic        wake_en_i,     // Wake enabled
   input wire logic        wake_o         // Wake pending
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (srst_i);

   // Chunk shape, order and hold
   chk_page_cross: assert property (
      bus_valid_o |-> 13'(bus_req_o.addr[11:0]) + 13'(bus_req_o.len)
      <= PAGE_BYTES) else $error("chunk crosses a page");
   chk_len_cap: assert property (
      bus_valid_o |-> bus_req_o.len != 8'h00 && bus_req_o.len <= MAX_REQ)
      else $error("chunk length out of range");
   chk_read_align: assert property (
      bus_valid_o && !bus_req_o.write
      |-> 8'(bus_req_o.addr[6:0]) + bus_req_o.len <= MAX_REQ)
      else $error("read chunk crosses a line");
   chk_chunk_hold: assert property (
      bus_valid_o && !bus_ready_i && !sw_rst_i
      |=> bus_valid_o && $stable(bus_req_o)) else $error("chunk dropped");
   chk_addr_next: assert property (
      bus_valid_o && bus_ready_i && !bus_req_o.last && !sw_rst_i
      |=> bus_valid_o && bus_req_o.addr == $past(bus_req_o.addr)
      + 64'($past(bus_req_o.len))) else $error("chunks not contiguous");
   // Link grant and power
   chk_gig_full: assert property (
      link_speed_o == SPD_1000 |-> link_full_o)
      else $error("half duplex at gigabit");
   chk_gig_s0: assert property (
      !sys_s0_i |=> link_speed_o != SPD_1000)
      else $error("gigabit outside working state");
   chk_d3_block: assert property (
      power_d3_i |=> !req_ready_o) else $error("request taken powered down");
   // Wake and soft reset
   chk_wake_set: assert property (
      rx_valid_i && wake_en_i && rx_hdr_i.wake_pkt && !sw_rst_i
      && rx_hdr_i.wake_mac == station_mac_i |=> wake_o)
      else $error("wake not raised");
   chk_soft_rst: assert property (
      sw_rst_i && lan_en_o |=> lan_en_o && !wake_o && !bus_valid_o)
      else $error("soft reset result wrong");
endmodule : gbe_shaping_monitor

bind gbe_host_request_shaping gbe_shaping_monitor i_mon (.*);

// File: verilog/gbe_host_request_shaping.sv
// Host request shaper with link, buffer, filter and wake control
// How it works
// - Split requests so none crosses 4 KB
// - Straddling buffer yields several bus requests
// - Each request at most 128 bytes, reads aligned
// - Writes start anywhere, may cross 64 bytes
// - Full duplex always, half only 10/100
// - Gigabit only in working state
// - Management link runs at three rates
// - Attached port transmits at half rate
// - Port setup loaded from NVM, no detect
// - Soft reset spares only the NVM port setup
// - Receive buffer size clamped to range
// - FIFO split in 1 KB steps of 32
// - Frames up to 9018 bytes accepted
// - Hash spreads receive over two queues
// - Bus addresses are 64 bits wide
// - Unicast, multicast hash, broadcast, promiscuous
// - Active and powered-down states supported
// - Wake on packet holding own address
`timescale 1ns/1ps

module gbe_host_request_shaping
   import gbe_shaping_pkg::*;
#(
   parameter int unsigned MC_TABLE_W = 128
) (
   input  wire logic                  ref_clk_i,          // 50 MHz clock
   input  wire logic                  srst_i,             // Sync reset
   input  wire logic                  sw_rst_i,           // Software reset
   // DMA request side
   input  wire logic                  req_valid_i,        // Request offered
   input  wire dma_req_t              req_i,              // Request fields
   output logic                       req_ready_o,        // Request taken
   // Bus side
   output logic                       bus_valid_o,        // Chunk offered
   output bus_req_t                   bus_req_o,          // Chunk fields
   input  wire logic                  bus_ready_i,        // Chunk taken
   // NVM loaded port setup
   input  wire logic                  nvm_valid_i,        // NVM load strobe
   input  wire logic                  nvm_lan_en_i,       // Port attached
   input  wire logic [1:0]            nvm_lan_port_i,     // Port number
   output logic                       lan_en_o,           // Port attached
   output logic [1:0]                 lan_port_o,         // Port number
   output logic                       lane_half_rate_o,   // Half rate tx
   // Link and power
   input  wire logic [1:0]            speed_req_i,        // Wanted rate
   input  wire logic                  half_req_i,         // Wanted half
   input  wire logic                  sys_s0_i,           // Working state
   input  wire logic                  power_d3_i,         // Powered down
   input  wire logic [1:0]            mgmt_rate_i,        // Mgmt rate sel
   output logic [1:0]                 link_speed_o,       // Granted rate
   output logic                       link_full_o,        // Full duplex
   output logic                       link_err_o,         // Request altered
   output logic                       mgmt_active_o,      // Mgmt link used
   output logic                       mgmt_clk_o,         // Mgmt link clock
   output logic                       pdown_o,            // MAC powered down
   // Buffers
   input  wire logic [14:0]           rx_buf_req_i,       // Buffer bytes
   input  wire logic [5:0]            rx_fifo_req_i,      // Rx FIFO in KB
   output logic [14:0]                rx_buf_size_o,      // Clamped size
   output logic [5:0]                 rx_fifo_kb_o,       // Rx FIFO KB
   output logic [5:0]                 tx_fifo_kb_o,       // Tx FIFO KB
   // Frame length check
   input  wire logic                  frame_valid_i,      // Length strobe
   input  wire logic [13:0]           frame_len_i,        // Frame bytes
   output logic                       frame_valid_o,      // Result strobe
   output logic                       frame_ok_o,         // Length legal
   // Receive filter and wake
   input  wire logic                  rx_valid_i,         // Header strobe
   input  wire rx_hdr_t               rx_hdr_i,           // Header fields
   input  wire logic [47:0]           station_mac_i,      // Own address
   input  wire logic [MC_TABLE_W-1:0] mc_table_i,         // Multicast table
   input  wire logic                  bcast_en_i,         // Take broadcast
   input  wire logic                  promisc_i,          // Take all
   input  wire logic                  hash_spread_en_i,   // Two queues on
   input  wire logic                  wake_en_i,          // Wake enabled
   input  wire logic                  wake_clr_i,         // Clear wake
   output logic                       rx_valid_o,         // Decision strobe
   output logic                       rx_accept_o,        // Frame kept
   output logic                       rx_queue_o,         // Queue index
   output logic                       wake_o              // Wake pending
);

   localparam int unsigned MC_IDX_W = $clog2(MC_TABLE_W);

   st_t q;
   st_t d;

   // Largest legal chunk at an address for the remaining length
   function automatic logic [7:0] chunk_len(
      input logic [63:0]      a,
      input logic [LEN_W-1:0] rem,
      input logic             wr
   );
      logic [12:0]      to_page;
      logic [7:0]       cap;
      logic [LEN_W-1:0] lim;
      to_page = PAGE_BYTES - {1'b0, a[11:0]};
      // Reads end on a 128-byte line, writes only cap the size
      cap = wr ? MAX_REQ : MAX_REQ - {1'b0, a[6:0]};
      lim = rem;
      if ({3'h0, to_page} < lim) begin
         lim = {3'h0, to_page};
      end
      if ({8'h00, cap} < lim) begin
         lim = {8'h00, cap};
      end
      return lim[7:0];
   endfunction : chunk_len

   logic [7:0]       first_len;
   logic [7:0]       next_len;
   logic [63:0]      next_addr;
   logic [LEN_W-1:0] next_rem;
   logic [7:0]       mgmt_div;
   logic [1:0]       lan_port_keep;
   logic             lan_en_keep;
   logic             mc_hit;
   logic             uc_hit;
   logic             bc_hit;
   logic             wake_hit;

   // Next state of the whole block
   always_comb begin
      d         = q;
      first_len = chunk_len(req_i.addr, req_i.len, req_i.write);
      next_addr = q.bus.addr + {56'h0, q.bus.len};
      next_rem  = q.rem - {8'h00, q.bus.len};
      next_len  = chunk_len(next_addr, next_rem, q.bus.write);

      // Request shaper
      case (q.state)
         SHP_IDLE: begin
            d.req_ready = ~power_d3_i;
            if (q.req_ready && req_valid_i &&
                req_i.len != '0) begin
               d.req_ready    = 1'b0;
               d.bus_valid    = 1'b1;
               d.bus.addr     = req_i.addr;
               d.bus.write    = req_i.write;
               d.bus.len      = first_len;
               d.bus.last     = ({8'h00, first_len} == req_i.len);
               d.rem          = req_i.len;
               d.state        = SHP_ISSUE;
            end
         end
         SHP_ISSUE: begin
            if (bus_ready_i) begin
               if (q.bus.last) begin
                  d.bus_valid = 1'b0;
                  d.req_ready = ~power_d3_i;
                  d.state     = SHP_IDLE;
               end else begin
                  // Buffer over a boundary goes out in pieces
                  d.bus.addr  = next_addr;
                  d.bus.len   = next_len;
                  d.bus.last  = ({8'h00, next_len} == next_rem);
                  d.rem       = next_rem;
               end
            end
         end
         default: begin
            d.state     = SHP_IDLE;
            d.bus_valid = 1'b0;
         end
      endcase

      // Port setup from NVM, no presence detection
      if (nvm_valid_i) begin
         d.lan_en   = nvm_lan_en_i;
         d.lan_port = nvm_lan_port_i;
      end

      // Link rate and duplex grant
      d.link_speed = speed_req_i;
      d.link_full  = ~half_req_i;
      d.link_err   = 1'b0;
      if (speed_req_i != SPD_10 && speed_req_i != SPD_100 &&
          speed_req_i != SPD_1000) begin
         d.link_speed = SPD_100;
         d.link_err   = 1'b1;
      end
      if (speed_req_i == SPD_1000 && !sys_s0_i) begin
         d.link_speed = SPD_100;
         d.link_err   = 1'b1;
      end
      if (d.link_speed == SPD_1000 && half_req_i) begin
         d.link_full  = 1'b1;
         d.link_err   = 1'b1;
      end

      // Management link clock in low power states
      case (mgmt_rate_i)
         MGMT_SEL_400K: mgmt_div = MGMT_DIV_400K;
         MGMT_SEL_1M:   mgmt_div = MGMT_DIV_1M;
         MGMT_SEL_100K: mgmt_div = MGMT_DIV_100K;
         default:       mgmt_div = MGMT_DIV_100K;
      endcase
      d.mgmt_active = ~sys_s0_i;
      if (q.mgmt_active) begin
         if (q.mgmt_cnt >= mgmt_div - 8'h01) begin
            d.mgmt_cnt = 8'h00;
            d.mgmt_clk = ~q.mgmt_clk;
         end else begin
            d.mgmt_cnt = q.mgmt_cnt + 8'h01;
         end
      end else begin
         d.mgmt_cnt = 8'h00;
         d.mgmt_clk = 1'b0;
      end
      d.pdown = power_d3_i;

      // Buffer sizing
      d.rx_buf_size = rx_buf_req_i;
      if (rx_buf_req_i < RX_BUF_MIN) begin
         d.rx_buf_size = RX_BUF_MIN;
      end else if (rx_buf_req_i > RX_BUF_MAX) begin
         d.rx_buf_size = RX_BUF_MAX;
      end
      d.rx_fifo_kb = (rx_fifo_req_i > FIFO_TOTAL_KB) ?
                     FIFO_TOTAL_KB : rx_fifo_req_i;
      d.tx_fifo_kb = FIFO_TOTAL_KB - d.rx_fifo_kb;

      // Frame length check
      d.frame_valid = frame_valid_i;
      if (frame_valid_i) begin
         d.frame_ok = (frame_len_i <= JUMBO_MAX);
      end

      // Address filter and queue choice
      uc_hit   = (rx_hdr_i.dst_mac == station_mac_i);
      bc_hit   = (rx_hdr_i.dst_mac == MAC_BCAST) & bcast_en_i;
      mc_hit   = rx_hdr_i.dst_mac[40] &
                 mc_table_i[rx_hdr_i.dst_mac[47 -: MC_IDX_W]];
      d.rx_valid = rx_valid_i;
      if (rx_valid_i) begin
         d.rx_accept = promisc_i | uc_hit | bc_hit | mc_hit;
         d.rx_queue  = hash_spread_en_i & rx_hdr_i.hash[0];
      end

      // Wake flag, set wins over clear
      wake_hit = rx_valid_i & wake_en_i & rx_hdr_i.wake_pkt &
                 (rx_hdr_i.wake_mac == station_mac_i);
      if (wake_hit) begin
         d.wake = 1'b1;
      end else if (wake_clr_i) begin
         d.wake = 1'b0;
      end

      // Software reset keeps the loaded port setup
      lan_port_keep = d.lan_port;
      lan_en_keep   = d.lan_en;
      if (sw_rst_i) begin
         d          = ST_RST;
         d.lan_port = lan_port_keep;
         d.lan_en   = lan_en_keep;
      end
   end

   // State register
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         q <= ST_RST;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign req_ready_o      = q.req_ready;
   assign bus_valid_o      = q.bus_valid;
   assign bus_req_o        = q.bus;
   assign lan_en_o         = q.lan_en;
   assign lan_port_o       = q.lan_port;
   assign lane_half_rate_o = q.lan_en;
   assign link_speed_o     = q.link_speed;
   assign link_full_o      = q.link_full;
   assign link_err_o       = q.link_err;
   assign mgmt_active_o    = q.mgmt_active;
   assign mgmt_clk_o       = q.mgmt_clk;
   assign pdown_o          = q.pdown;
   assign rx_buf_size_o    = q.rx_buf_size;
   assign rx_fifo_kb_o     = q.rx_fifo_kb;
   assign tx_fifo_kb_o     = q.tx_fifo_kb;
   assign frame_valid_o    = q.frame_valid;
   assign frame_ok_o       = q.frame_ok;
   assign rx_valid_o       = q.rx_valid;
   assign rx_accept_o      = q.rx_accept;
   assign rx_queue_o       = q.rx_queue;
   assign wake_o           = q.wake;

endmodule : gbe_host_request_shaping

// File: verilog/gbe_shaping_pkg.sv
// Shared constants and types for the host request shaping block
package gbe_shaping_pkg;

   // Clock
   localparam int unsigned CLK_HZ = 50_000_000;

   // Request shaping
   localparam int unsigned LEN_W       = 16;
   localparam logic [12:0] PAGE_BYTES  = 13'h1000;
   localparam logic [7:0]  MAX_REQ     = 8'h80;

   // Line rate codes
   localparam logic [1:0]  SPD_10      = 2'h0;
   localparam logic [1:0]  SPD_100     = 2'h1;
   localparam logic [1:0]  SPD_1000    = 2'h2;

   // Management link rates, half period in clock cycles (rounded up)
   localparam int unsigned MGMT_100K_HZ = 100_000;
   localparam int unsigned MGMT_400K_HZ = 400_000;
   localparam int unsigned MGMT_1M_HZ   = 1_000_000;
   localparam logic [7:0]  MGMT_DIV_100K =
      8'((CLK_HZ + 2 * MGMT_100K_HZ - 1) / (2 * MGMT_100K_HZ));
   localparam logic [7:0]  MGMT_DIV_400K =
      8'((CLK_HZ + 2 * MGMT_400K_HZ - 1) / (2 * MGMT_400K_HZ));
   localparam logic [7:0]  MGMT_DIV_1M   =
      8'((CLK_HZ + 2 * MGMT_1M_HZ - 1) / (2 * MGMT_1M_HZ));
   localparam logic [1:0]  MGMT_SEL_100K = 2'h0;
   localparam logic [1:0]  MGMT_SEL_400K = 2'h1;
   localparam logic [1:0]  MGMT_SEL_1M   = 2'h2;

   // Buffer and frame limits
   localparam logic [14:0] RX_BUF_MIN    = 15'h0100;
   localparam logic [14:0] RX_BUF_MAX    = 15'h4000;
   localparam logic [5:0]  FIFO_TOTAL_KB = 6'h20;
   localparam logic [13:0] JUMBO_MAX     = 14'h233A;
   localparam logic [47:0] MAC_BCAST     = 48'hFFFF_FFFF_FFFF;

   // Shaper states
   typedef enum logic [0:0] {
      SHP_IDLE,
      SHP_ISSUE
   } shp_state_t;

   // One outgoing bus request
   typedef struct packed {
      logic [63:0] addr;
      logic [7:0]  len;
      logic        write;
      logic        last;
   } bus_req_t;

   // Incoming master request from the DMA engines
   typedef struct packed {
      logic [63:0]      addr;
      logic [LEN_W-1:0] len;
      logic             write;
   } dma_req_t;

   // Received header summary for filtering
   typedef struct packed {
      logic [47:0] dst_mac;
      logic [31:0] hash;
      logic        wake_pkt;
      logic [47:0] wake_mac;
   } rx_hdr_t;

   // Whole block state
   typedef struct packed {
      shp_state_t       state;
      logic             req_ready;
      logic             bus_valid;
      bus_req_t         bus;
      logic [LEN_W-1:0] rem;
      logic [1:0]       lan_port;
      logic             lan_en;
      logic [1:0]       link_speed;
      logic             link_full;
      logic             link_err;
      logic             mgmt_active;
      logic             mgmt_clk;
      logic [7:0]       mgmt_cnt;
      logic [14:0]      rx_buf_size;
      logic [5:0]       rx_fifo_kb;
      logic [5:0]       tx_fifo_kb;
      logic             frame_valid;
      logic             frame_ok;
      logic             rx_valid;
      logic             rx_accept;
      logic             rx_queue;
      logic             wake;
      logic             pdown;
   } st_t;

   localparam st_t ST_RST = '0;

endpackage : gbe_shaping_pkg
